// ==== include/dts_pkg.sv ====
/*
 * Constants for the split-mode dual 8-bit timer: register indices, field
 * positions, reset values and command encodings.
 * Assumes a 32-bit Avalon-MM slave port, one register per aligned word,
 * so the byte address of a register is four times its index.
 */
package dts_pkg;

    // ********************************************************************
    // Register indices (byte address is four times the index).
    // ********************************************************************
    localparam logic [5:0] IDX_CLOCK_ENABLE = 6'h00;
    localparam logic [5:0] IDX_PIN_OVERRIDE = 6'h01;
    localparam logic [5:0] IDX_FORCED_OUT = 6'h02;
    localparam logic [5:0] IDX_MODE_SELECT = 6'h03;
    localparam logic [5:0] IDX_CMD_CLEAR = 6'h04;
    localparam logic [5:0] IDX_CMD_SET = 6'h05;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0a;
    localparam logic [5:0] IDX_IRQ_FLAGS = 6'h0b;
    localparam logic [5:0] IDX_COUNT_BASE = 6'h20;
    localparam logic [5:0] IDX_PERIOD_BASE = 6'h26;
    localparam logic [5:0] IDX_COMPARE_BASE = 6'h28;

    // ********************************************************************
    // Field positions and widths.
    // ********************************************************************
    localparam int ENABLE_BIT = 0;
    localparam int TICK_SEL_LSB = 1;
    localparam int DUAL_SEL_BIT = 0;
    localparam int CMD_LSB = 2;
    localparam int TARGET_LSB = 0;
    localparam int MATCH_FLAG_LSB = 4;
    localparam int UPPER_CH_LSB = 4;
    localparam int NUM_CH = 3;
    localparam int PRESCALE_W = 10;

    // ********************************************************************
    // Reset values and encodings.
    // ********************************************************************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] PIN_FIELD_MASK = 8'h77;
    localparam logic [7:0] IRQ_FIELD_MASK = 8'h73;
    localparam logic [1:0] TARGET_FIELD_MASK = 2'h3;
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_RESTART = 2'h2;
    localparam logic [1:0] CMD_HARD_RESET = 2'h3;
    localparam logic [1:0] TARGET_BOTH = 2'h3;

endpackage : dts_pkg

// ==== rtl/dts_timer_split.sv ====
/*
 * Split-mode dual 8-bit down-counting timer with its control, command,
 * waveform-pin override and interrupt-enable logic, behind an Avalon-MM
 * slave with waitrequest.
 * Assumes all inputs synchronous to ref_clk_in (10 MHz) and a bus master
 * that holds each request until it sees waitrequest low.
 */

module dts_timer_split (
    input wire logic ref_clk_in, // 10 MHz peripheral clock.
    input wire logic rst_b_in, // Asynchronous reset, active low.
    input wire logic [7:0] avs_address_in, // Byte address.
    input wire logic avs_read_in, // Read request.
    input wire logic avs_write_in, // Write request.
    input wire logic [31:0] avs_writedata_in, // Write data.
    input wire logic [3:0] avs_byteenable_in, // Byte enables.
    output logic [31:0] avs_readdata_out, // Read data.
    output logic avs_waitrequest_out, // Stall while high.
    input wire logic [5:0] port_out_reg_in, // Port output register values.
    output logic [5:0] waveform_pin_out, // Level driven to the pads.
    output logic [5:0] logic_wave_out, // Waveforms to the logic block.
    output logic irq_out // Interrupt request, level.
);

    // ********************************************************************
    // Bus slave: one wait cycle, then the answer.
    // ********************************************************************
    logic ack_q;
    logic [7:0] rd_mux;
    wire logic req = avs_read_in | avs_write_in;
    wire logic [5:0] idx = avs_address_in[7:2];
    wire logic wr_acc = avs_write_in & ack_q & avs_byteenable_in[0];
    wire logic [7:0] wdata = avs_writedata_in[7:0];

    // Writes take effect only at the edge where waitrequest is low.
    assign avs_waitrequest_out = req & ~ack_q;

    // The ack pulse lasts one cycle so back-to-back requests each wait.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data is captured in the wait cycle and stands in the ack cycle.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in & ~ack_q) begin
            avs_readdata_out <= {24'h00_0000, rd_mux};
        end
    end

    // ********************************************************************
    // Control registers.
    // ********************************************************************
    logic [7:0] clock_enable;
    logic [7:0] pin_override;
    logic [7:0] forced_out;
    logic [7:0] mode_select;
    logic [1:0] target_sel;
    logic [7:0] irq_enable;
    logic [7:0] irq_flags;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
        hit = (a == b);
    endfunction : hit

    wire logic wr_set = wr_acc & hit(idx, dts_pkg::IDX_CMD_SET);
    wire logic wr_clr = wr_acc & hit(idx, dts_pkg::IDX_CMD_CLEAR);
    wire logic enabled = clock_enable[dts_pkg::ENABLE_BIT];
    wire logic dual_mode = mode_select[dts_pkg::DUAL_SEL_BIT];
    wire logic [2:0] tick_sel = clock_enable[dts_pkg::TICK_SEL_LSB +: 3];
    wire logic [1:0] cmd_code = wdata[dts_pkg::CMD_LSB +: 2];
    wire logic [1:0] next_target = wr_set ? (target_sel | wdata[1:0])
                                          : (target_sel & ~wdata[1:0]);
    // Reserved codes of either field fall through as no action.
    wire logic cmd_both = wr_set & (next_target == dts_pkg::TARGET_BOTH);
    wire logic do_restart = cmd_both & (cmd_code == dts_pkg::CMD_RESTART);
    wire logic do_hard = cmd_both & (cmd_code == dts_pkg::CMD_HARD_RESET)
                         & ~enabled;

    // Plain read/write configuration registers.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clock_enable <= dts_pkg::CTRL_RESET;
            pin_override <= dts_pkg::CTRL_RESET;
            forced_out <= dts_pkg::CTRL_RESET;
            mode_select <= dts_pkg::CTRL_RESET;
            irq_enable <= dts_pkg::CTRL_RESET;
        end else if (wr_acc) begin
            if (hit(idx, dts_pkg::IDX_CLOCK_ENABLE)) clock_enable <= wdata & 8'h0f;
            if (hit(idx, dts_pkg::IDX_PIN_OVERRIDE)) begin
                pin_override <= wdata & dts_pkg::PIN_FIELD_MASK;
            end
            if (hit(idx, dts_pkg::IDX_FORCED_OUT)) forced_out <= wdata & dts_pkg::PIN_FIELD_MASK;
            if (hit(idx, dts_pkg::IDX_MODE_SELECT)) mode_select <= wdata & 8'h01;
            if (hit(idx, dts_pkg::IDX_IRQ_ENABLE)) irq_enable <= wdata & dts_pkg::IRQ_FIELD_MASK;
        end
    end

    // Target field through its set and clear views; the command is not kept.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            target_sel <= 2'h0;
        end else if (wr_set | wr_clr) begin
            target_sel <= next_target;
        end
    end

    // ********************************************************************
    // Prescaler and tick.
    // ********************************************************************
    logic [dts_pkg::PRESCALE_W-1:0] prescale;
    logic [dts_pkg::PRESCALE_W-1:0] tick_mask;

    // Mask of low prescaler bits that must all be ones for a tick.
    always_comb begin
        unique case (tick_sel)
            3'h0: tick_mask = 10'h000;
            3'h1: tick_mask = 10'h001;
            3'h2: tick_mask = 10'h003;
            3'h3: tick_mask = 10'h007;
            3'h4: tick_mask = 10'h00f;
            3'h5: tick_mask = 10'h03f;
            3'h6: tick_mask = 10'h0ff;
            3'h7: tick_mask = 10'h3ff;
        endcase
    end

    wire logic running = enabled & dual_mode;
    wire logic tick = running & ((prescale & tick_mask) == tick_mask);

    // A restart also restarts the prescaler so the first period is whole.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prescale <= '0;
        end else if (!running | do_restart) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 10'h001;
        end
    end

    // ********************************************************************
    // Counters, periods, compares and waveforms, low timer 0, high 1.
    // ********************************************************************
    logic [7:0] count [2];
    logic [7:0] period [2];
    logic [7:0] compare [2][dts_pkg::NUM_CH];
    logic [5:0] wave;
    logic [7:0] flag_set;

    for (genvar t = 0; t < 2; t++) begin : g_tmr
        logic [7:0] next_count;
        wire logic wr_cnt = wr_acc & hit(idx, dts_pkg::IDX_COUNT_BASE + 6'(t));
        wire logic wr_per = wr_acc & hit(idx, dts_pkg::IDX_PERIOD_BASE + 6'(t));

        // Bus write is applied last so it wins over every other source.
        always_comb begin
            next_count = count[t];
            if (do_hard) begin
                next_count = dts_pkg::COUNT_RESET;
            end else if (do_restart) begin
                next_count = period[t];
            end else if (tick) begin
                next_count = (count[t] == 8'h00) ? period[t]
                                                 : count[t] - 8'h01;
            end
            if (wr_cnt) begin
                next_count = wdata;
            end
        end

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                count[t] <= dts_pkg::COUNT_RESET;
                period[t] <= dts_pkg::PERIOD_RESET;
            end else begin
                count[t] <= next_count;
                if (wr_per) period[t] <= wdata;
                else if (do_hard) period[t] <= dts_pkg::PERIOD_RESET;
            end
        end

        for (genvar n = 0; n < dts_pkg::NUM_CH; n++) begin : g_ch
            localparam int W = 3 * t + n;
            wire logic wr_cmp = wr_acc
                & hit(idx, dts_pkg::IDX_COMPARE_BASE + 6'(2 * n + t));

            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    compare[t][n] <= dts_pkg::COMPARE_RESET;
                end else if (wr_cmp) begin
                    compare[t][n] <= wdata;
                end else if (do_hard) begin
                    compare[t][n] <= dts_pkg::COMPARE_RESET;
                end
            end

            // Disabled timer shows the forced value; running, the compare result.
            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    wave[W] <= 1'b0;
                end else if (!enabled) begin
                    wave[W] <= forced_out[4 * t + n];
                end else if (dual_mode) begin
                    wave[W] <= count[t] < compare[t][n];
                end
            end

            // The pad only follows the waveform when the override is set.
            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    waveform_pin_out[W] <= 1'b0;
                    logic_wave_out[W] <= 1'b0;
                end else begin
                    waveform_pin_out[W] <= pin_override[4 * t + n] ? wave[W]
                                           : port_out_reg_in[W];
                    logic_wave_out[W] <= wave[W];
                end
            end
        end
    end

    // ********************************************************************
    // Interrupt flags and request.
    // ********************************************************************
    // Flags rise on a counting tick, so a stopped timer raises nothing.
    always_comb begin
        flag_set = 8'h00;
        flag_set[0] = tick & (count[0] == 8'h00);
        flag_set[1] = tick & (count[1] == 8'h00);
        for (int n = 0; n < dts_pkg::NUM_CH; n++) begin
            flag_set[dts_pkg::MATCH_FLAG_LSB + n] =
                tick & (count[0] == compare[0][n]);
        end
    end

    wire logic [7:0] flag_clr = (wr_acc & hit(idx, dts_pkg::IDX_IRQ_FLAGS)) ? wdata : 8'h00;

    // A set in the same cycle as its clear wins, so no event is lost.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_flags <= 8'h00;
        end else if (do_hard) begin
            irq_flags <= flag_set;
        end else begin
            irq_flags <= (irq_flags & ~flag_clr) | flag_set;
        end
    end

    assign irq_out = |(irq_flags & irq_enable);

    // ********************************************************************
    // Read multiplexer; unmapped addresses read zero.
    // ********************************************************************
    always_comb begin
        rd_mux = 8'h00;
        unique case (idx)
            dts_pkg::IDX_CLOCK_ENABLE: rd_mux = clock_enable;
            dts_pkg::IDX_PIN_OVERRIDE: rd_mux = pin_override;
            dts_pkg::IDX_FORCED_OUT: rd_mux = forced_out;
            dts_pkg::IDX_MODE_SELECT: rd_mux = mode_select;
            dts_pkg::IDX_CMD_CLEAR,
            dts_pkg::IDX_CMD_SET: rd_mux = {6'h00, target_sel};
            dts_pkg::IDX_IRQ_ENABLE: rd_mux = irq_enable;
            dts_pkg::IDX_IRQ_FLAGS: rd_mux = irq_flags;
            6'h20: rd_mux = count[0];
            6'h21: rd_mux = count[1];
            6'h26: rd_mux = period[0];
            6'h27: rd_mux = period[1];
            6'h28: rd_mux = compare[0][0];
            6'h29: rd_mux = compare[1][0];
            6'h2a: rd_mux = compare[0][1];
            6'h2b: rd_mux = compare[1][1];
            6'h2c: rd_mux = compare[0][2];
            6'h2d: rd_mux = compare[1][2];
            default: rd_mux = 8'h00;
        endcase
    end

    // ********************************************************************
    // Checks.
    // ********************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    // Cycles since the last tick, saturating at 15, for the spacing check.
    logic [3:0] gap;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) gap <= 4'h0;
        else if (tick) gap <= 4'h0;
        else if (gap != 4'hf) gap <= gap + 4'h1;
    end

    chk_slowest_tick_gap: assert property (
        tick & ($past(tick_sel) == 3'h7) & $past(tick) |-> 0)
        else $error("divide by 1024 gave ticks back to back");
    chk_tick_spacing: assert property (
        tick & (tick_sel == 3'h2) & $stable(tick_sel) & ($past(tick_sel, 4) == 3'h2)
        & $past(running, 4) |-> gap == 4'h3)
        else $error("divide by 4 tick spacing wrong");
    chk_disabled_holds: assert property (
        !enabled & !wr_acc |=> count[0] == $past(count[0]))
        else $error("counter moved while disabled");
    chk_forced_value: assert property (
        !enabled |=> wave == {$past(forced_out[6:4]), $past(forced_out[2:0])})
        else $error("forced value not on waveform");
    chk_pad_follows_port: assert property (
        !pin_override[0] |=> waveform_pin_out[0] == $past(port_out_reg_in[0]))
        else $error("pad overridden without enable");
    chk_clear_view_bits: assert property (
        wr_clr |=> target_sel == ($past(target_sel) & ~$past(wdata[1:0])))
        else $error("clear view changed wrong bits");
    chk_set_view_bits: assert property (
        wr_set |=> target_sel == ($past(target_sel) | $past(wdata[1:0])))
        else $error("set view changed wrong bits");
    chk_restart_reload: assert property (
        wr_set & (wdata[3:2] == 2'h2) & ((target_sel | wdata[1:0]) == 2'h3)
        |=> count[0] == period[0] && count[1] == period[1])
        else $error("restart did not reload counters");
    chk_hard_reset_gate: assert property (
        wr_set & (wdata[3:0] == 4'hf) & enabled
        |=> period[0] == $past(period[0]) && period[1] == $past(period[1]))
        else $error("hard reset acted while enabled");
    chk_cmd_reads_zero: assert property (
        avs_read_in & ack_q & (idx == dts_pkg::IDX_CMD_SET) |-> avs_readdata_out[3:2] == 2'h0)
        else $error("command field read nonzero");
    chk_write_priority: assert property (
        wr_acc & (idx == dts_pkg::IDX_COUNT_BASE) |=> count[0] == $past(wdata))
        else $error("counter write lost to counting");
    chk_underflow_reload: assert property (
        tick & (count[1] == 8'h00) & !wr_acc |=> irq_flags[1] && count[1] == $past(period[1]))
        else $error("underflow did not flag and reload");
    chk_irq_gated: assert property (
        (irq_enable == 8'h00) |-> !irq_out)
        else $error("interrupt raised with all enables off");
    chk_match_flag_set: assert property (
        tick & (count[0] == compare[0][0]) |=> irq_flags[dts_pkg::MATCH_FLAG_LSB])
        else $error("compare match did not raise its flag");
    chk_flag_sticky: assert property (
        irq_flags[0] & !wr_acc |=> irq_flags[0])
        else $error("underflow flag dropped without a clear");
    chk_upper_pin_route: assert property (
        pin_override[dts_pkg::UPPER_CH_LSB] |=> waveform_pin_out[3] == $past(wave[3]))
        else $error("upper override did not route waveform");

endmodule : dts_timer_split

// ==== sim/tb.sv ====
/*
 * Self-checking bench for the split-mode dual 8-bit timer: reset values,
 * field masks, pin override and forced values, tick divider, flags and
 * interrupt gating, and the set/clear command views.
 * Assumes dts_timer_split compiled before it; the bench drives every port.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ********************************************************************
    // Signals, counters and the design under test.
    // ********************************************************************
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h00000000;
    logic [3:0] avs_byteenable_in = 4'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [5:0] port_out_reg_in = 6'h2a;
    logic [5:0] waveform_pin_out;
    logic [5:0] logic_wave_out;
    logic irq_out;
    int fail_count = 0;
    int tests_run = 0;
    int n;
    logic [31:0] rd;
    logic [31:0] held;
    int div_tab [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
    logic [5:0] idx_tab [15] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h0a, 6'h0b,
        6'h20, 6'h21, 6'h26, 6'h27, 6'h28, 6'h2d, 6'h07};
    logic [7:0] rst_tab [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    logic [7:0] irq_tab [5] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h40};

    dts_timer_split u_dts_timer_split (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .port_out_reg_in(port_out_reg_in), .waveform_pin_out(waveform_pin_out),
        .logic_wave_out(logic_wave_out), .irq_out(irq_out)
    );

    // The 10 MHz clock.
    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    // ********************************************************************
    // Bus and comparison tasks.
    // ********************************************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One Avalon transfer; the request is held until waitrequest is seen low.
    task bus(input logic wr, input logic [5:0] idx, input logic [7:0] val);
        @(posedge ref_clk_in);
        avs_address_in <= {idx, 2'b00};
        avs_writedata_in <= {24'h000000, val};
        avs_byteenable_in <= 4'hf;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        do begin
            @(posedge ref_clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask : bus

    task rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rd, {24'h000000, exp});
    endtask : rd_chk

    // Pins lag a forced-value write by two edges, so three are allowed.
    task pin_chk(input logic [5:0] pin_exp, input logic [5:0] wave_exp);
        repeat (3) @(negedge ref_clk_in);
        check({26'h0, waveform_pin_out}, {26'h0, pin_exp});
        check({26'h0, logic_wave_out}, {26'h0, wave_exp});
    endtask : pin_chk

    task irq_chk(input logic exp);
        @(negedge ref_clk_in);
        check({31'h0, irq_out}, {31'h0, exp});
    endtask : irq_chk

    // Counts settled cycles until pin 0 rises; gives up after 5000.
    task wait_rise(output int cnt);
        logic prev;
        cnt = 0;
        do begin
            prev = waveform_pin_out[0];
            @(negedge ref_clk_in);
            cnt++;
        end while (!(prev === 1'b0 && waveform_pin_out[0] === 1'b1) && cnt < 5000);
    endtask : wait_rise

    task tally_and_finish();
        $display("counts: %0d comparisons, %0d mismatches", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog: the tests need well under 20000 cycles.
    initial begin
        #6000000;
        fail_count++;
        tally_and_finish();
    end

    // ********************************************************************
    // Test sequence.
    // ********************************************************************
    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 15; i++) rd_chk(idx_tab[i], rst_tab[i]);
        bus(1'b1, 6'h07, 8'h5a);
        rd_chk(6'h07, 8'h00);
        $display("test reset_values done");
        bus(1'b1, 6'h01, 8'hff);
        rd_chk(6'h01, 8'h77);
        bus(1'b1, 6'h0a, 8'hff);
        rd_chk(6'h0a, 8'h73);
        bus(1'b1, 6'h0a, 8'h00);
        bus(1'b1, 6'h03, 8'hff);
        rd_chk(6'h03, 8'h01);
        // Forced values while disabled, then no override and partial override.
        bus(1'b1, 6'h02, 8'h35);
        pin_chk(6'h1d, 6'h1d);
        bus(1'b1, 6'h01, 8'h00);
        pin_chk(6'h2a, 6'h1d);
        bus(1'b1, 6'h01, 8'h41);
        pin_chk(6'h0b, 6'h1d);
        $display("test pins done");
        // Period 1 and compare 1 make pin 0 rise every second tick.
        bus(1'b1, 6'h28, 8'h01);
        bus(1'b1, 6'h26, 8'h01);
        bus(1'b1, 6'h01, 8'h01);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 6'h00, {4'h0, i[2:0], 1'b1});
            repeat (3) wait_rise(n);
            check(n, 2 * div_tab[i]);
        end
        bus(1'b1, 6'h00, 8'h00);
        bus(1'b0, 6'h20, 8'h00);
        held = rd;
        repeat (20) @(posedge ref_clk_in);
        rd_chk(6'h20, held[7:0]);
        pin_chk(6'h2b, 6'h1d);
        rd_chk(6'h0b, 8'h73);
        $display("test tick_divider done");
        irq_chk(1'b0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 6'h0a, irq_tab[i]);
            irq_chk(1'b1);
            bus(1'b1, 6'h0b, irq_tab[i]);
            irq_chk(1'b0);
        end
        rd_chk(6'h0b, 8'h00);
        $display("test interrupts done");
        // Commands: reserved, restart, target none, hard reset gated by enable.
        bus(1'b1, 6'h20, 8'h05);
        rd_chk(6'h20, 8'h05);
        bus(1'b1, 6'h05, 8'h03);
        rd_chk(6'h04, 8'h03);
        bus(1'b1, 6'h05, 8'h04);
        rd_chk(6'h20, 8'h05);
        bus(1'b1, 6'h05, 8'h08);
        rd_chk(6'h20, 8'h01);
        rd_chk(6'h00, 8'h00);
        rd_chk(6'h05, 8'h03);
        bus(1'b1, 6'h04, 8'h01);
        rd_chk(6'h05, 8'h02);
        bus(1'b1, 6'h04, 8'h02);
        bus(1'b1, 6'h05, 8'h0c);
        rd_chk(6'h26, 8'h01);
        bus(1'b1, 6'h00, 8'h01);
        bus(1'b1, 6'h05, 8'h0f);
        rd_chk(6'h26, 8'h01);
        bus(1'b1, 6'h00, 8'h00);
        bus(1'b1, 6'h05, 8'h0c);
        rd_chk(6'h26, 8'hff);
        rd_chk(6'h20, 8'h00);
        $display("test commands done");
        tally_and_finish();
    end

endmodule : tb
